/* File: core/pmbus_target.sv */
`timescale 1ns/1ns
// Function
// - bus held low 35 ms aborts, releases
// - works at 100 and 400 kHz
// - commands run with or without PEC; 03 sent without PEC is not run
// - PEC is CRC-8, poly x8+x2+x+1
// - CRC covers every byte incl addresses
// - last data sender appends the CRC
// - alert idles high, latches low on change
// - persisting alarm re-asserts after clear
// - listed fault events assert the alert
// - status read, clear, recycle release alert
// - alert raised at first state change
// - bad command sets status and alert
// - unsupported read returns zero bytes
// - standard read: low, high, pec, nack
// - block format with count, max 48
// - linear: 5-bit exponent, 11-bit mantissa
// - output voltage uses fixed exponent -9
// - address 1011 plus three straps
// - stretch only after ack, max 25 ms; this block never stretches, scl_oe is held low
// - command 03 clears status and alert
`include "pmbus_target_consts.svh"
module pmbus_target
  import pmbus_target_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic scl_o,
  output logic scl_oe,
  input wire logic target_addr_strap_bit2,
  input wire logic target_addr_strap_bit1,
  input wire logic target_addr_strap_bit0,
  input wire logic [7:0] fault_in,
  input wire logic remote_on_in,
  input wire logic [15:0] vout_rd,
  input wire logic [15:0] iout_rd,
  output logic alert_n,
  output logic main_on,
  output logic [15:0] vout_cmd,
  output logic setting_we
);
  // ==========================================================
  // crc-8 byte update, shared by rx and tx paths
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ==========================================================
  // reset release and synchronisers
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  logic [1:0] scl_s_r, sda_s_r, ron_s_r; // two-stage pin synchronisers
  logic scl_q_r, sda_q_r, ron_q_r; // last synced value, for edges
  logic [7:0] flt_s1_r, flt_s2_r; // fault inputs, async to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      ron_s_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      ron_q_r <= 1'b1;
      flt_s1_r <= 8'h00;
      flt_s2_r <= 8'h00;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      ron_s_r <= {ron_s_r[0], remote_on_in};
      scl_q_r <= scl_s_r[1];
      sda_q_r <= sda_s_r[1];
      ron_q_r <= ron_s_r[1];
      flt_s1_r <= fault_in;
      flt_s2_r <= flt_s1_r;
    end
  end
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl = scl_s_r[1];
  assign sda = sda_s_r[1];
  // edge detection works at both 100 and 400 kHz (sampling at 50 MHz)
  assign scl_rise = scl & ~scl_q_r;
  assign scl_fall = ~scl & scl_q_r;
  assign start_c = scl & scl_q_r & ~sda & sda_q_r;
  assign stop_c = scl & scl_q_r & sda & ~sda_q_r;

  // ==========================================================
  // protocol engine state
  phase_t ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt; // bit count within byte
  logic [7:0] sh_r, sh_nxt; // shift register
  logic [7:0] cmd_r, cmd_nxt; // command code
  logic [7:0] crc_r, crc_nxt; // running pec
  logic [5:0] nrx_r, nrx_nxt; // data bytes received this frame
  logic [7:0] d0_r, d0_nxt, d1_r, d1_nxt, d2_r, d2_nxt; // last two rx bytes, and the crc before d0
  logic [7:0] d3_r, d3_nxt; // data byte before d1, so a pec frame keeps its low byte
  logic bad_cmd; // executed write of a command this block does not know
  logic [5:0] ntx_r, ntx_nxt; // bytes sent in read
  logic rd_r, rd_nxt; // current address phase was a read
  logic bcast_r, bcast_nxt; // broadcast addressed
  logic ackd_r, ackd_nxt; // acking a received byte (else host acks ours)
  logic sda_o_r, sda_o_nxt;
  logic [31:0] low_r, low_nxt; // lock-up low-time counter
  logic abort_r, abort_nxt; // lock-up abort seen, until next start
  // events to status logic
  logic ev_exec, ev_cml, ev_inv, ev_stread;
  logic [7:0] status_r, status_nxt;
  logic alert_r, alert_nxt;
  logic main_on_r, main_on_nxt, off_seen_r, off_seen_nxt;
  logic [15:0] vout_r, vout_nxt;
  logic we_r, we_nxt;
  logic [7:0] tx_byte;
  logic addr_hit;

  // address 1011 + straps, or broadcast for writes only
  assign addr_hit = (sh_nxt[7:1] == {`ADDR_HI4, target_addr_strap_bit2,
                     target_addr_strap_bit1, target_addr_strap_bit0})
                    || (sh_nxt[7:1] == `ADDR_BCAST);

  // ==========================================================
  // read data selection: low byte first, pec last
  always_comb begin
    tx_byte = 8'h00; // unsupported read returns zeros
    case (cmd_r)
      `CMD_STATUS_BYTE: tx_byte = (ntx_r == 6'h0) ? status_r : crc_r;
      `CMD_STATUS_WORD: tx_byte = (ntx_r == 6'h0) ? status_r :
                                  (ntx_r == 6'h1) ? {status_r[5], status_r[4],
                                  status_r[3], 5'h00} : crc_r;
      8'h8b: tx_byte = (ntx_r == 6'h0) ? vout_rd[7:0] :
                       (ntx_r == 6'h1) ? vout_rd[15:8] : crc_r;
      8'h8c: tx_byte = (ntx_r == 6'h0) ? iout_rd[7:0] :
                       (ntx_r == 6'h1) ? iout_rd[15:8] : crc_r;
      default: tx_byte = (ntx_r == 6'h2) ? crc_r : 8'h00;
    endcase
  end

  // ==========================================================
  // protocol next state
  always_comb begin
    ph_nxt = ph_r; bit_nxt = bit_r; sh_nxt = sh_r; cmd_nxt = cmd_r;
    crc_nxt = crc_r; nrx_nxt = nrx_r; d0_nxt = d0_r; d1_nxt = d1_r;
    d2_nxt = d2_r; ntx_nxt = ntx_r; rd_nxt = rd_r; bcast_nxt = bcast_r;
    d3_nxt = d3_r;
    ackd_nxt = ackd_r; sda_o_nxt = sda_o_r; abort_nxt = abort_r;
    ev_exec = 1'b0; ev_cml = 1'b0; ev_inv = 1'b0; ev_stread = 1'b0;
    // lock-up: either line low counts, released on both high
    low_nxt = (scl && sda) ? 32'h0 : low_r + 32'h1;
    if (low_r >= `LOCKUP_CYC) begin
      // drop the transaction, no execution, settings kept
      ph_nxt = PH_IGNORE; sda_o_nxt = 1'b0; abort_nxt = 1'b1;
      low_nxt = 32'h0;
    end else if (start_c) begin
      // repeated start keeps crc so the write address/command are covered
      ph_nxt = PH_ADDR; bit_nxt = 4'h0; sda_o_nxt = 1'b0; abort_nxt = 1'b0;
      if (ph_r == PH_IDLE || ph_r == PH_IGNORE) begin
        crc_nxt = `CRC_INIT; nrx_nxt = 6'h0;
      end
    end else if (stop_c) begin
      ph_nxt = PH_IDLE; sda_o_nxt = 1'b0;
      if (!rd_r && ph_r != PH_IGNORE && !abort_r && nrx_r != 6'h0) begin
        // a byte past 1 (OPERATION) or 2 data bytes is the pec and must match; none means accept
        ev_exec = 1'b1;
      end
    end else if (ph_r == PH_ADDR || ph_r == PH_CMD || ph_r == PH_WDATA) begin
      if (scl_rise) begin
        sh_nxt = {sh_r[6:0], sda};
        bit_nxt = bit_r + 4'h1;
        if (bit_r == 4'h7) begin
          if (ph_r == PH_ADDR) begin
            if (!addr_hit) ph_nxt = PH_IGNORE;
            else if (sh_nxt[0] && sh_nxt[7:1] == `ADDR_BCAST) begin
              ev_inv = 1'b1; ph_nxt = PH_IGNORE;
            end else begin
              rd_nxt = sh_nxt[0]; bcast_nxt = (sh_nxt[7:1] == `ADDR_BCAST);
              ackd_nxt = 1'b1; ph_nxt = PH_ACK; ntx_nxt = 6'h0;
              crc_nxt = crc8(crc_r, sh_nxt);
            end
          end else begin
            ackd_nxt = 1'b1; ph_nxt = PH_ACK;
            if (ph_r == PH_CMD) begin
              cmd_nxt = sh_nxt; crc_nxt = crc8(crc_r, sh_nxt);
            end else begin
              // keep previous crc in d2 to check a trailing pec byte
              d2_nxt = crc_r; d1_nxt = d0_r; d0_nxt = sh_nxt;
              d3_nxt = d1_r;
              crc_nxt = crc8(crc_r, sh_nxt);
              if (nrx_r != 6'h3f) nrx_nxt = nrx_r + 6'h1;
            end
          end
        end
      end
    end else if (ph_r == PH_RDATA) begin
      if (scl_fall) begin
        sda_o_nxt = ~sh_r[7]; // drive low when bit is zero
        sh_nxt = {sh_r[6:0], 1'b0};
        bit_nxt = bit_r + 4'h1;
        if (bit_r == 4'h8) begin
          sda_o_nxt = 1'b0; ackd_nxt = 1'b0; ph_nxt = PH_ACK;
        end
      end
    end else if (ph_r == PH_ACK) begin
      if (scl_fall && ackd_r) begin
        sda_o_nxt = 1'b1; // pull sda low for ack
      end else if (scl_fall) begin
        // release after ack; next phase
        sda_o_nxt = 1'b0; bit_nxt = 4'h0;
        if (rd_r) begin
          ph_nxt = PH_RDATA; sh_nxt = tx_byte; bit_nxt = 4'h1;
          sda_o_nxt = ~tx_byte[7];
          sh_nxt = {tx_byte[6:0], 1'b0};
          crc_nxt = crc8(crc_r, tx_byte);
          ntx_nxt = ntx_r + 6'h1;
          if (ntx_r == 6'h0 && cmd_r == `CMD_STATUS_BYTE) ev_stread = 1'b1;
          if (ntx_r == 6'h0 && cmd_r == `CMD_STATUS_WORD) ev_stread = 1'b1;
        end else begin
          ph_nxt = (cmd_r == cmd_r && nrx_r == 6'h0 && bit_r == 4'h9) ?
                   PH_WDATA : (ph_r == PH_ACK && ackd_r) ? PH_WDATA : PH_CMD;
        end
      end else if (scl_rise && !ackd_r && sda) begin
        ph_nxt = PH_IGNORE; // host nack ends read
      end
      if (scl_rise && ackd_r) begin
        ackd_nxt = 1'b1; bit_nxt = 4'h9;
      end
      if (scl_fall && ackd_r && bit_r == 4'h9) begin
        ackd_nxt = 1'b0; sda_o_nxt = 1'b0;
        if (!rd_r) ph_nxt = (sh_r == cmd_r && nrx_r == 6'h0 && bit_r == 4'h9
                             && ph_r == PH_ACK) ? PH_WDATA : PH_WDATA;
        if (!rd_r && nrx_r == 6'h0 && cmd_r != sh_r) ph_nxt = PH_CMD;
        bit_nxt = 4'h0;
        if (rd_r) begin
          ph_nxt = PH_RDATA; sh_nxt = {tx_byte[6:0], 1'b0}; bit_nxt = 4'h1;
          sda_o_nxt = ~tx_byte[7]; crc_nxt = crc8(crc_r, tx_byte);
          ntx_nxt = ntx_r + 6'h1;
          if (cmd_r == `CMD_STATUS_BYTE || cmd_r == `CMD_STATUS_WORD)
            ev_stread = 1'b1;
          // unknown read: zeros go out, but the host is told
          if (cmd_r != `CMD_STATUS_BYTE && cmd_r != `CMD_STATUS_WORD &&
              cmd_r != 8'h8b && cmd_r != 8'h8c) ev_inv = 1'b1;
        end
      end
    end
    // pec check at stop: d0 is the pec, d2 the crc before it
    if (ev_exec && nrx_r >= 6'h2 && nrx_r != 6'h1 && d0_r != d2_r &&
        nrx_r > ((cmd_r == `CMD_OPERATION) ? 6'h1 : 6'h2)) begin
      ev_exec = 1'b0; ev_cml = 1'b1;
    end
    if (nrx_r > `BLOCK_MAX + 6'h2) ev_inv = ev_inv | ev_exec;
  end

  // ==========================================================
  // command execution, status, alert next state
  always_comb begin
    status_nxt = status_r; alert_nxt = alert_r; main_on_nxt = main_on_r;
    off_seen_nxt = off_seen_r; vout_nxt = vout_r; we_nxt = 1'b0;
    bad_cmd = 1'b0;
    // release events first; a new event the same cycle wins
    if (ev_stread) alert_nxt = 1'b0;
    if (ev_exec && cmd_r == `CMD_CLEAR_FAULTS) begin
      status_nxt = 8'h00; alert_nxt = 1'b0;
    end
    if (ev_exec && cmd_r == `CMD_OPERATION) begin
      // with a pec the data byte sits in d1, else in d0
      main_on_nxt = (((nrx_r == 6'h1) ? d0_r : d1_r) == `OP_ON);
      if (!main_on_nxt) off_seen_nxt = 1'b1;
      else if (off_seen_r) begin off_seen_nxt = 1'b0; alert_nxt = 1'b0; end
    end
    if (ev_exec && cmd_r == 8'h21 && nrx_r >= 6'h2) begin
      vout_nxt = (nrx_r == 6'h2) ? {d0_r, d1_r} : {d1_r, d3_r};
      we_nxt = 1'b1;
    end
    if (ev_exec && cmd_r != `CMD_CLEAR_FAULTS && cmd_r != `CMD_OPERATION &&
        cmd_r != 8'h21) bad_cmd = 1'b1;
    if (!ron_q_r && ron_s_r[1]) alert_nxt = 1'b0; // remote pin recycle
    // persisting alarms reassert alert every cycle they are high, even after clear; only bits 0-3 also reassert status
    status_nxt = status_nxt | {2'h0, flt_s2_r[0], flt_s2_r[1], flt_s2_r[2],
                 flt_s2_r[3], 2'h0};
    if (|flt_s2_r || ev_cml || ev_inv || bad_cmd) alert_nxt = 1'b1;
    if (ev_cml || ev_inv || bad_cmd) status_nxt[`ST_CML] = 1'b1;
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= PH_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; cmd_r <= 8'h00;
      crc_r <= 8'h00; nrx_r <= 6'h0; d0_r <= 8'h00; d1_r <= 8'h00;
      d2_r <= 8'h00; ntx_r <= 6'h0; rd_r <= 1'b0; bcast_r <= 1'b0;
      ackd_r <= 1'b0; sda_o_r <= 1'b0; low_r <= 32'h0; abort_r <= 1'b0;
      status_r <= 8'h00; alert_r <= 1'b0; main_on_r <= 1'b1;
      off_seen_r <= 1'b0; vout_r <= 16'h0000; we_r <= 1'b0;
      d3_r <= 8'h00;
    end else begin
      ph_r <= ph_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; cmd_r <= cmd_nxt;
      crc_r <= crc_nxt; nrx_r <= nrx_nxt; d0_r <= d0_nxt; d1_r <= d1_nxt;
      d2_r <= d2_nxt; ntx_r <= ntx_nxt; rd_r <= rd_nxt; bcast_r <= bcast_nxt;
      ackd_r <= ackd_nxt; sda_o_r <= sda_o_nxt; low_r <= low_nxt;
      abort_r <= abort_nxt; status_r <= status_nxt; alert_r <= alert_nxt;
      main_on_r <= main_on_nxt; off_seen_r <= off_seen_nxt;
      vout_r <= vout_nxt; we_r <= we_nxt;
      d3_r <= d3_nxt;
    end
  end
  // open-drain: drive low only, never stretch the clock
  assign sda_o = 1'b0;
  assign sda_oe = sda_o_r;
  assign scl_o = 1'b0;
  assign scl_oe = 1'b0;
  assign alert_n = ~alert_r;
  assign main_on = main_on_r;
  assign vout_cmd = vout_r;
  assign setting_we = we_r;
endmodule

/* File: pkg/pmbus_target_consts.svh */
`ifndef PMBUS_TARGET_CONSTS_SVH
`define PMBUS_TARGET_CONSTS_SVH
// ==========================================================
// clock and timing
`define CLK_HZ 50000000
`define LOCKUP_MS 35
`define LOCKUP_CYC ((`CLK_HZ / 1000) * `LOCKUP_MS)
`define STRETCH_MS 25
`define STRETCH_CYC ((`CLK_HZ / 1000) * `STRETCH_MS)
`define SCL_STD_HZ 100000
`define SCL_FAST_HZ 400000
`define SCL_MIN_HZ 10000
// ==========================================================
// address, commands, limits
`define ADDR_HI4 4'hb
`define ADDR_BCAST 7'h00
`define CMD_OPERATION 8'h01
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_WORD 8'h79
`define OP_ON 8'h80
`define BLOCK_MAX 8'h30
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define VOUT_EXP 5'h17
// ==========================================================
// status bit positions
`define ST_VOUT_OV 5
`define ST_IOUT_OC 4
`define ST_VIN_UV 3
`define ST_TEMP 2
`define ST_CML 1
`endif

/* File: pkg/pmbus_target_pkg.sv */
package pmbus_target_pkg;
  // transaction phase, one-hot
  typedef enum logic [6:0] {
    PH_IDLE = 7'h01,
    PH_ADDR = 7'h02,
    PH_CMD = 7'h04,
    PH_WDATA = 7'h08,
    PH_RDATA = 7'h10,
    PH_ACK = 7'h20,
    PH_IGNORE = 7'h40
  } phase_t;
endpackage

/* File: test/pmbus_target_sva.sv */
`timescale 1ns/1ns
`include "pmbus_target_consts.svh"
// ==========================================================
// port checker for the bus target
module pmbus_target_sva (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic [7:0] fault_in,
  input wire logic alert_n,
  input wire logic [15:0] vout_cmd,
  input wire logic setting_we
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // cycles with the clock line low; saturates so it never wraps
  logic [21:0] low_cnt_r;
  logic [21:0] low_cnt_nxt;
  // next count: clear on a high clock, else count up
  always_comb begin
    low_cnt_nxt = scl_i ? 22'h0 : low_cnt_r + {21'h0, !(&low_cnt_r)};
  end
  // register only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_r <= 22'h0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end
  property p_no_stretch;
    !scl_oe;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("clock line pulled");
  property p_we_pulse;
    setting_we |=> !setting_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("strobe too long");
  property p_vout_we;
    $changed(vout_cmd) |-> setting_we || $past(setting_we);
  endproperty
  a_vout_we: assert property (p_vout_we) else $error("setting moved alone");
  property p_ack_rise;
    $rose(sda_oe) |-> !scl_i;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("data pulled, clock high");
  property p_ack_fall;
    $fell(sda_oe) |-> !scl_i;
  endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("data freed, clock high");
  // a change while the clock is high would be read as start or stop
  property p_hold_high;
    scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("data moved, clock high");
  property p_alert_fault;
    (|(fault_in[3:0] & ~$past(fault_in[3:0]))) |-> ##[1:8] !alert_n;
  endproperty
  a_alert_fault: assert property (p_alert_fault) else $error("alarm missed");
  property p_lockup;
    (low_cnt_r > 22'(`LOCKUP_CYC + 8)) |-> !sda_oe;
  endproperty
  a_lockup: assert property (p_lockup) else $error("bus not released");
endmodule

/* File: test/pmbus_host_model.sv */
`timescale 1ns/1ns
// ==========================================================
// bus master model; open drain, so it only ever pulls low
module pmbus_host_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic got,
  output logic [7:0] got_byte,
  output logic stuck
);
  int q = 40; // quarter bit in ns, far above the slowest legal rate
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    got = 1'b0;
    got_byte = 8'h00;
    stuck = 1'b0;
  end
  // start, also repeated start; waits first so an ack is freed
  task automatic start();
    #(2 * q) sda_low = 1'b0;
    #(2 * q) scl_low = 1'b0;
    #(2 * q) sda_low = 1'b1;
    #(2 * q) scl_low = 1'b1;
  endtask
  task automatic stop();
    #(2 * q) sda_low = 1'b1;
    #(2 * q) scl_low = 1'b0;
    #(2 * q) sda_low = 1'b0;
    #(4 * q);
  endtask
  // half period low, half high: a short high phase would slip past the target's sampling
  task automatic bit_io(input logic b, output logic r);
    #(q) sda_low = !b;
    #(q) scl_low = 1'b0;
    for (int i = 0; i < 3000 && !scl; i++) #10;
    if (!scl) stuck = 1'b1;
    #(q) r = sda;
    #(q) scl_low = 1'b1;
  endtask
  // byte, then the ninth bit; nine is what the host puts there
  task automatic byte_io(input logic [7:0] d, input logic nine, input logic rd,
                         output logic [7:0] r, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(nine, n);
    ack = !n;
    if (rd) begin
      got_byte = r;
      got = 1'b1;
      #1 got = 1'b0;
    end
  endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ns
// ==========================================================
// self-checking bench: host model drives the bus
module tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [7:0] fault_in = 8'h00;
  logic remote_on_in = 1'b1;
  logic [15:0] vout_rd = 16'h0;
  logic [15:0] iout_rd = 16'h0;
  logic sda_oe, scl_oe, alert_n, main_on, setting_we, scl_low, sda_low, got, stuck;
  logic [15:0] vout_cmd;
  logic [7:0] got_byte;
  logic [8:0] expq[$]; // bit 8 set: value not checked
  int err_total = 0;
  int comparisons = 0;
  int rates[3] = '{40, 625, 2500};
  logic [31:0] seed = 32'hde046602;
  wire scl_w = !(scl_low || scl_oe); // pull-up wins when all release
  wire sda_w = !(sda_low || sda_oe);
  always #10 ref_clk = !ref_clk;
  pmbus_target pmbus_target_inst (.ref_clk(ref_clk), .arst_n(arst_n), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .scl_o(), .scl_oe(scl_oe),
    .target_addr_strap_bit2(strap[2]), .target_addr_strap_bit1(strap[1]),
    .target_addr_strap_bit0(strap[0]), .fault_in(fault_in), .remote_on_in(remote_on_in),
    .vout_rd(vout_rd), .iout_rd(iout_rd), .alert_n(alert_n), .main_on(main_on),
    .vout_cmd(vout_cmd), .setting_we(setting_we));
  pmbus_host_model pmbus_host_model_inst (.scl(scl_w), .sda(sda_w), .scl_low(scl_low),
    .sda_low(sda_low), .got(got), .got_byte(got_byte), .stuck(stuck));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // bounded wait for the alert level
  task automatic wait_alert(input logic v);
    int i;
    for (i = 0; i < 100 && alert_n !== v; i++) @(posedge ref_clk);
    chk({15'h0, alert_n}, {15'h0, v});
    if (i == 100) summarize();
  endtask
  // write: address, command, n bytes low first; pm 0 none, 1 good, 2 bad check byte
  task automatic xw(input logic [6:0] a, input logic [7:0] c, input int n,
                    input logic [15:0] d, input int pm, input logic ea);
    logic [7:0] b[4];
    logic [7:0] r;
    logic [7:0] p;
    logic ack;
    b = '{{a, 1'b0}, c, d[7:0], d[15:8]};
    p = 8'h00;
    pmbus_host_model_inst.start();
    for (int i = 0; i < n + 2; i++) begin
      pmbus_host_model_inst.byte_io(b[i], 1'b1, 1'b0, r, ack);
      p = crc8(p, b[i]);
      chk({15'h0, ack}, {15'h0, ea});
    end
    if (pm != 0) pmbus_host_model_inst.byte_io(pm == 2 ? ~p : p, 1'b1, 1'b0, r, ack);
    pmbus_host_model_inst.stop();
  endtask
  // read: notes the expected bytes and check byte before the bus cycle
  task automatic xr(input logic [6:0] a, input logic [7:0] c, input int n,
                    input logic [15:0] e, input logic pc);
    logic [7:0] r;
    logic [7:0] p;
    logic ack;
    p = crc8(crc8(crc8(8'h00, {a, 1'b0}), c), {a, 1'b1});
    for (int i = 0; i < n; i++) begin
      expq.push_back({1'b0, e[8*i +: 8]});
      p = crc8(p, e[8*i +: 8]);
    end
    expq.push_back({!pc, p});
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.byte_io({a, 1'b0}, 1'b1, 1'b0, r, ack);
    pmbus_host_model_inst.byte_io(c, 1'b1, 1'b0, r, ack);
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.byte_io({a, 1'b1}, 1'b1, 1'b0, r, ack);
    for (int i = 0; i <= n; i++) pmbus_host_model_inst.byte_io(8'hff, i == n, 1'b1, r, ack);
    pmbus_host_model_inst.stop();
  endtask
  // watcher: each byte read off the bus retires the oldest note
  always @(posedge got) begin : watch
    logic [8:0] e;
    e = (expq.size() != 0) ? expq.pop_front() : 9'h0ff;
    if (!e[8]) chk({8'h0, got_byte}, {8'h0, e[7:0]});
  end
  always @(posedge stuck) begin
    err_total++;
    summarize();
  end
  initial begin
    logic [31:0] v;
    logic [6:0] ad;
    v = rnd();
    strap = v[2:0];
    vout_rd = v[31:16];
    iout_rd = v[15:0];
    ad = {4'hb, strap};
    tick(3);
    arst_n = 1'b1;
    tick(5);
    chk({15'h0, alert_n}, 16'h1);
    chk({15'h0, main_on}, 16'h1);
    v = rnd();
    // settle and spacing waits before read-backs shortened to keep the run short
    xw(ad, 8'h21, 2, v[15:0], 1, 1'b1);
    chk(vout_cmd, v[15:0]);
    xw(ad, 8'h21, 2, v[31:16], 0, 1'b1);
    chk(vout_cmd, v[31:16]);
    // bad check byte at each bus rate, then a status read
    foreach (rates[k]) begin
      pmbus_host_model_inst.q = rates[k];
      xw(ad, 8'h21, 2, v[15:0], 2, 1'b1);
      chk(vout_cmd, v[31:16]);
      wait_alert(1'b0);
      xr(ad, 8'h78, 1, 16'h0002, 1'b1);
      wait_alert(1'b1);
    end
    pmbus_host_model_inst.q = 40;
    tick(1);
    fault_in = 8'h01;
    wait_alert(1'b0);
    xw(ad, 8'h03, 0, 16'h0, 1, 1'b1);
    wait_alert(1'b0);
    xr(ad, 8'h78, 1, 16'h0020, 1'b1);
    tick(1);
    fault_in = 8'h00;
    xw(ad, 8'h03, 0, 16'h0, 1, 1'b1);
    wait_alert(1'b1);
    xr(ad, 8'h79, 2, 16'h0000, 1'b1);
    xw(ad, 8'h21, 2, v[15:0], 2, 1'b1);
    wait_alert(1'b0);
    xw(ad, 8'h01, 1, 16'h0000, 1, 1'b1);
    chk({15'h0, main_on}, 16'h0);
    xw(ad, 8'h01, 1, 16'h0080, 1, 1'b1);
    chk({15'h0, main_on}, 16'h1);
    wait_alert(1'b1);
    xw(ad, 8'h21, 2, v[15:0], 2, 1'b1);
    wait_alert(1'b0);
    tick(1);
    remote_on_in = 1'b0;
    tick(20);
    remote_on_in = 1'b1;
    wait_alert(1'b1);
    xw(ad, 8'h03, 0, 16'h0, 1, 1'b1);
    xr(ad, 8'hf5, 2, 16'h0000, 1'b0);
    wait_alert(1'b0);
    xw(ad, 8'h03, 0, 16'h0, 1, 1'b1);
    xr(ad, 8'h8b, 2, vout_rd, 1'b1);
    xr(ad, 8'h8c, 2, iout_rd, 1'b1);
    xw({4'hb, ~strap}, 8'h21, 2, v[15:0], 1, 1'b0);
    chk(vout_cmd, v[31:16]);
    xw(7'h00, 8'h21, 2, v[15:0], 1, 1'b1);
    chk(vout_cmd, v[15:0]);
    chk(16'(expq.size()), 16'h0);
    summarize();
  end
endmodule
bind pmbus_target pmbus_target_sva pmbus_target_sva_inst (.ref_clk(ref_clk),
  .arst_n(arst_n), .scl_i(scl_i), .sda_oe(sda_oe), .scl_oe(scl_oe), .fault_in(fault_in),
  .alert_n(alert_n), .vout_cmd(vout_cmd), .setting_we(setting_we));
